// file: inc/spx_consts.vh
// Purpose: Constants for the strobe processor execution core
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Included by hdl/spx_exec_core.v
//
// Overview of operation
// RULE1 - Z decrement op lowers Z by one, zero wraps to all ones
// RULE2 - Y decrement op lowers Y by one, zero wraps to all ones
// RULE3 - Y increment op raises Y by one, all ones wraps to zero
// RULE4 - Saturating increment loads min(Y+1, M); Y all ones gives M
// RULE5 - Random load fills low Y bits of X from generator, clears upper bits
// RULE6 - Random load with Y zero or above eight fills all eight bits
// RULE7 - Back to back random loads may reuse one generator value
// RULE8 - Interrupt op sets the program interrupt flag
// RULE9 - Wait on X holds PC, decrements X per overflow, then advances, flags done
// RULE10 - Wait on X with X zero does not wait
// RULE11 - Wait on W stalls for W overflows, zero means 32, then flags done
// RULE12 - Wait on event stalls until timer at least compare value, no flag
// RULE13 - Loop label records address of following instruction
// RULE14 - Label in last location records its own address
// RULE15 - Only one loop start kept; a new label replaces the old
// RULE16 - Repeat jumps to loop start when C xor N true, else advances
// RULE17 - Repeat without a recorded label always falls through
// RULE18 - Skip advances PC by S plus one when C xor N true, else one
// RULE19 - Skip with S zero holds until C xor N becomes true
// RULE20 - Skip decode: bit7 clear, S bits 6-4, N bit 3, C bits 2-0
// RULE21 - Undefined opcodes behave as no operation and advance
// RULE22 - Sequencing steps at 8 MHz
// RULE23 - M from bits 2-0 of saturating increment, W from bits 4-0 of wait
// RULE24 - Condition C selects one of eight external status inputs
`ifndef SPX_CONSTS_VH
`define SPX_CONSTS_VH

// Register byte offsets
`define SPX_CTRL_OFS      8'h00
`define SPX_STATUS_OFS    8'h04
`define SPX_WORK_X_OFS    8'h08
`define SPX_WORK_Y_OFS    8'h0c
`define SPX_WORK_Z_OFS    8'h10
`define SPX_PROG_PTR_OFS  8'h14
`define SPX_PROG_DATA_OFS 8'h18
`define SPX_TCMP_OFS      8'h1c

// Field positions
`define SPX_CTRL_START_BIT 0
`define SPX_CTRL_STOP_BIT  1
`define SPX_ST_RUN_BIT     0
`define SPX_ST_INT_BIT     1
`define SPX_ST_WT_BIT      2

// Reset values
`define SPX_WORK_RST 8'h00
`define SPX_TCMP_RST 16'h0000

// Opcodes, and the count that a zero wait field means
`define SPX_Z_DECREMENT_OP         8'hbf
`define SPX_Y_DECREMENT_OP         8'hbe
`define SPX_Y_INCREMENT_OP         8'hbd
`define SPX_Y_SATURATING_INC_OP    8'hb0
`define SPX_RANDOM_LOAD_OP         8'hbc
`define SPX_INTERRUPT_OP           8'hb9
`define SPX_WAIT_COUNT_FROM_REG_OP 8'hbb
`define SPX_WAIT_COUNT_OP          8'h80
`define SPX_WAIT_TIMER_COMPARE_OP  8'hb8
`define SPX_LOOP_LABEL_OP          8'hba
`define SPX_CONDITIONAL_REPEAT_OP  8'ha0
`define SPX_WAIT_ZERO_MEANS        6'h20

// Timing: system clock and sequencing rate in MHz
`define SPX_CLK_MHZ  5'h14
`define SPX_STEP_MHZ 5'h08

`endif

// file: hdl/spx_exec_core.v
// Purpose: Execution core for the non-strobe instructions of a strobe processor
// Assumes: APB slave on sys_clk_i; timer and status inputs on the same clock
// Notes:   Strobe opcodes 0xc0-0xff run as no operation; AW must be 3 or more
//          Steps come from a fractional divider, two in every five clocks, so
//          the sequencer sees an average 8 MHz rate without a second clock.
//          Overflow pulses between steps are latched, so several count as one.
//          A CPU write to X, Y or Z in a step cycle beats the instruction.
//          A program that runs past the last word stops and rearms pc at zero.
`timescale 1ns/1ps
`include "spx_consts.vh"

module spx_exec_core #(
   parameter AW = 5,   // Program memory address width
   parameter TW = 16   // MAC timer width
) (
   // Clock and reset
   input  wire          sys_clk_i,
   input  wire          arst_n_i,
   // APB slave
   input  wire          psel_i,
   input  wire          penable_i,
   input  wire          pwrite_i,
   input  wire [7:0]    paddr_i,
   input  wire [31:0]   pwdata_i,
   output reg  [31:0]   prdata_o,
   output reg           pready_o,
   output reg           pslverr_o,
   // MAC timer, random generator and status
   input  wire          mac_ovf_i,
   input  wire [TW-1:0] mac_timer_i,
   input  wire [7:0]    random_generator_output_i,
   input  wire [7:0]    cond_status_i,
   // Flags
   output reg           program_interrupt_flag_o,
   output reg           wait_done_flag_o,
   output reg           running_o
);

   // Program memory depth and the pc constants at the pc's own width
   localparam DEPTH = 1 << AW;
   localparam [AW:0] PC_ONE  = {{AW{1'b0}}, 1'b1};
   localparam [AW:0] PC_LAST = {1'b0, {AW{1'b1}}};
   localparam [4:0]  STEP    = `SPX_STEP_MHZ;
   localparam [4:0]  MODULUS = `SPX_CLK_MHZ;

   // Mask of the low bits loaded by a random load
   function [7:0] rand_mask;
      input [7:0] y;
      begin
         if (y == 8'h00 || y > 8'h08) begin
            rand_mask = 8'hff;
         end else begin
            rand_mask = 8'hff >> (4'h8 - y[3:0]);
         end
      end
   endfunction

   // One-step decrement with wrap from zero to all ones, shared by X, Y and Z
   function [7:0] dec8;
      input [7:0] v;
      begin
         dec8 = v - 8'h01;
      end
   endfunction

   // Reset synchroniser, program memory and sequencer state
   reg           rst_meta_r;
   reg           rst_n_r;
   reg  [7:0]    mem [0:DEPTH-1];
   reg  [AW:0]   pc_r;
   reg  [AW-1:0] wptr_r;
   reg  [7:0]    x_r;
   reg  [7:0]    y_r;
   reg  [7:0]    z_r;
   reg  [TW-1:0] tcmp_r;
   reg  [AW:0]   label_r;
   reg           label_vld_r;
   reg           wact_r;
   reg  [5:0]    wcnt_r;
   reg           ovf_pend_r;
   reg  [4:0]    acc_r;
   reg           tick_r;

   // Next values and decode helpers
   reg  [AW:0]   pc_nxt;
   reg  [7:0]    x_nxt;
   reg  [7:0]    y_nxt;
   reg  [7:0]    z_nxt;
   reg  [AW:0]   label_nxt;
   reg           label_vld_nxt;
   reg           wact_nxt;
   reg  [5:0]    wcnt_nxt;
   reg           int_set;
   reg           wt_set;
   reg  [5:0]    wcur;
   reg  [7:0]    ysum;
   reg  [31:0]   rd_mux;
   reg           addr_ok;

   // Current instruction and the terms derived from it
   wire [7:0]    instr    = mem[pc_r[AW-1:0]];
   wire          cond_hit = cond_status_i[instr[2:0]] ^ instr[3]; // see RULE24
   wire          ovf_seen = ovf_pend_r | mac_ovf_i;
   wire          step     = tick_r & running_o;
   wire          apb_done = psel_i & penable_i & pready_o;
   wire          apb_wr   = apb_done & pwrite_i & ~pslverr_o;
   wire [AW:0]   pc_inc   = pc_r + PC_ONE;
   wire [AW:0]   pc_skip  = pc_r + {{(AW-2){1'b0}}, instr[6:4]} + PC_ONE;

   // Reset release through two flip-flops
   // Assertion stays asynchronous; only the release is timed to the clock,
   // so no register leaves reset on a different edge from its neighbours
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // Fractional divider giving an average 8 MHz step from 20 MHz
   // Two ticks in every five clocks; the spacing is uneven, which is why
   // overflow pulses are latched between ticks rather than sampled on them
   always @(posedge sys_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         acc_r  <= 5'h00;
         tick_r <= 1'b0;
      end else if (acc_r + STEP >= MODULUS) begin
         acc_r  <= acc_r + STEP - MODULUS; // see RULE22
         tick_r <= 1'b1;
      end else begin
         acc_r  <= acc_r + STEP;
         tick_r <= 1'b0;
      end
   end

   // Instruction decode and execution for one step
   // Every next value but wact_nxt defaults to holding, so an instruction that waits
   // simply leaves pc_nxt at pc_r and retries on the next step. The wait
   // counter only stays armed while a counted wait keeps asking for it,
   // so any other opcode drops a half-finished count.
   always @* begin
      pc_nxt        = pc_r;
      x_nxt         = x_r;
      y_nxt         = y_r;
      z_nxt         = z_r;
      label_nxt     = label_r;
      label_vld_nxt = label_vld_r;
      wact_nxt      = 1'b0;
      wcnt_nxt      = wcnt_r;
      int_set       = 1'b0;
      wt_set        = 1'b0;
      wcur          = 6'h00;
      ysum          = y_r + 8'h01;
      if (!instr[7]) begin
         // Conditional skip
         // A skip may run past the last word; the sequencer treats that as the end
         if (cond_hit) begin
            pc_nxt = pc_skip;                // see RULE18 RULE20
         end else if (instr[6:4] != 3'h0) begin
            pc_nxt = pc_inc;                 // see RULE18
         end                                 // Hold when S is zero, see RULE19
      end else if (instr[7:5] == 3'h4) begin
         // Counted wait, W from the low five bits
         // The first step loads the count, later steps use the armed counter
         wcur = wact_r ? wcnt_r :
                (instr[4:0] == 5'h00) ? `SPX_WAIT_ZERO_MEANS : {1'b0, instr[4:0]}; // see RULE23
         if (ovf_seen && wcur == 6'h01) begin
            pc_nxt = pc_inc;                 // see RULE11
            wt_set = 1'b1;
         end else begin
            wact_nxt = 1'b1;
            wcnt_nxt = ovf_seen ? wcur - 6'h01 : wcur;
         end
      end else if (instr[7:3] == 5'h16) begin
         // Saturating increment with limit M from the low three bits
         // Y of all ones would wrap to zero, so it is forced to the limit instead
         if (y_r == 8'hff || ysum > {5'h00, instr[2:0]}) begin
            y_nxt = {5'h00, instr[2:0]};     // see RULE4 RULE23
         end else begin
            y_nxt = ysum;                    // see RULE4
         end
         pc_nxt = pc_inc;
      end else if (instr[7:4] == 4'ha) begin
         // Conditional repeat
         // Without a label the jump is refused and execution falls through
         if (cond_hit && label_vld_r) begin
            pc_nxt = label_r;                // see RULE16
         end else begin
            pc_nxt = pc_inc;                 // see RULE16 RULE17
         end
      end else begin
         pc_nxt = pc_inc;
         case (instr)
            `SPX_Z_DECREMENT_OP: begin
               z_nxt = dec8(z_r);            // see RULE1
            end
            `SPX_Y_DECREMENT_OP: begin
               y_nxt = dec8(y_r);            // see RULE2
            end
            `SPX_Y_INCREMENT_OP: begin
               y_nxt = ysum;                 // see RULE3
            end
            `SPX_RANDOM_LOAD_OP: begin
               // Generator value is sampled directly, see RULE7
               x_nxt = random_generator_output_i & rand_mask(y_r); // see RULE5 RULE6
            end
            `SPX_INTERRUPT_OP: begin
               int_set = 1'b1;               // see RULE8
            end
            `SPX_WAIT_COUNT_FROM_REG_OP: begin
               // X doubles as the counter, so software sees it count down
               if (x_r == 8'h00) begin
                  wt_set = 1'b1;             // see RULE10
               end else if (ovf_seen) begin
                  x_nxt = dec8(x_r);         // see RULE9
                  if (x_r == 8'h01) begin
                     wt_set = 1'b1;          // see RULE9
                  end else begin
                     pc_nxt = pc_r;
                  end
               end else begin
                  pc_nxt = pc_r;             // see RULE9
               end
            end
            `SPX_WAIT_TIMER_COMPARE_OP: begin
               // Unsigned compare; no wait flag is raised when it ends
               if (mac_timer_i < tcmp_r) begin
                  pc_nxt = pc_r;             // see RULE12
               end
            end
            `SPX_LOOP_LABEL_OP: begin
               // A label in the last word points at itself, so a repeat stays in memory
               label_nxt     = (pc_r == PC_LAST) ? pc_r : pc_inc; // see RULE13 RULE14
               label_vld_nxt = 1'b1;         // see RULE15
            end
            default: begin
               pc_nxt = pc_inc;              // see RULE21
            end
         endcase
      end
   end

   // Register read multiplexer and address check
   // Only exact word offsets decode; any other address is refused with an
   // error response and reads back as zero
   always @* begin
      rd_mux  = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr_i)
         `SPX_CTRL_OFS:      rd_mux = 32'h0000_0000;
         `SPX_STATUS_OFS: begin
            rd_mux[`SPX_ST_RUN_BIT] = running_o;
            rd_mux[`SPX_ST_INT_BIT] = program_interrupt_flag_o;
            rd_mux[`SPX_ST_WT_BIT]  = wait_done_flag_o;
            rd_mux[8+AW:8]          = pc_r;
         end
         `SPX_WORK_X_OFS:    rd_mux[7:0] = x_r;
         `SPX_WORK_Y_OFS:    rd_mux[7:0] = y_r;
         `SPX_WORK_Z_OFS:    rd_mux[7:0] = z_r;
         `SPX_PROG_PTR_OFS:  rd_mux[AW-1:0] = wptr_r;
         `SPX_PROG_DATA_OFS: rd_mux = 32'h0000_0000;
         `SPX_TCMP_OFS:      rd_mux[TW-1:0] = tcmp_r;
         default:            addr_ok = 1'b0;
      endcase
   end

   // APB answer after one wait state
   // Read data is captured on the access edge and held with pready, so the
   // master takes a value that was settled a full cycle before it samples it.
   // pready falls again at once, which spaces back to back transfers safely.
   always @(posedge sys_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~addr_ok;
         if (psel_i && penable_i && !pready_o) begin
            prdata_o <= (addr_ok && !pwrite_i) ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // Program memory fill, no reset on the array
   // The array keeps its contents over reset and over a stop, so software
   // must load a program before the first start
   always @(posedge sys_clk_i) begin
      if (apb_wr && paddr_i == `SPX_PROG_DATA_OFS) begin
         mem[wptr_r] <= pwdata_i[7:0];
      end
   end

   // Sequencer state; software writes come last so they win on the data registers
   // A step that would leave the memory ends the program and rearms pc at zero.
   // Start and stop both rearm pc and drop the label; stop is written last, so
   // a write that sets both bits leaves the core stopped
   always @(posedge sys_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pc_r                     <= {(AW+1){1'b0}};
         wptr_r                   <= {AW{1'b0}};
         x_r                      <= `SPX_WORK_RST;
         y_r                      <= `SPX_WORK_RST;
         z_r                      <= `SPX_WORK_RST;
         tcmp_r                   <= `SPX_TCMP_RST;
         label_r                  <= {(AW+1){1'b0}};
         label_vld_r              <= 1'b0;
         wact_r                   <= 1'b0;
         wcnt_r                   <= 6'h00;
         ovf_pend_r               <= 1'b0;
         running_o                <= 1'b0;
         program_interrupt_flag_o <= 1'b0;
         wait_done_flag_o         <= 1'b0;
      end else begin
         // Overflows between steps are held until the next step
         // Several pulses between two steps therefore count as one
         ovf_pend_r <= tick_r ? 1'b0 : ovf_seen;
         // Write one to clear, a set in the same cycle wins
         // Clearing loses to a set so an event landing on the clear is never lost
         if (apb_wr && paddr_i == `SPX_STATUS_OFS) begin
            if (pwdata_i[`SPX_ST_INT_BIT]) program_interrupt_flag_o <= 1'b0;
            if (pwdata_i[`SPX_ST_WT_BIT])  wait_done_flag_o         <= 1'b0;
         end
         if (step) begin
            x_r         <= x_nxt;
            y_r         <= y_nxt;
            z_r         <= z_nxt;
            label_r     <= label_nxt;
            label_vld_r <= label_vld_nxt;
            wact_r      <= wact_nxt;
            wcnt_r      <= wcnt_nxt;
            if (int_set) program_interrupt_flag_o <= 1'b1; // see RULE8
            if (wt_set)  wait_done_flag_o         <= 1'b1; // see RULE9 RULE11
            // Leaving the memory ends the program
            if (pc_nxt > PC_LAST) begin
               running_o   <= 1'b0;
               pc_r        <= {(AW+1){1'b0}};
               label_vld_r <= 1'b0;
               wact_r      <= 1'b0;
            end else begin
               pc_r <= pc_nxt;
            end
         end
         if (apb_wr) begin
            case (paddr_i)
               `SPX_CTRL_OFS: begin
                  if (pwdata_i[`SPX_CTRL_START_BIT]) begin
                     running_o   <= 1'b1;
                     pc_r        <= {(AW+1){1'b0}};
                     label_vld_r <= 1'b0;
                     wact_r      <= 1'b0;
                  end
                  if (pwdata_i[`SPX_CTRL_STOP_BIT]) begin
                     running_o   <= 1'b0;
                     pc_r        <= {(AW+1){1'b0}};
                     label_vld_r <= 1'b0;
                     wact_r      <= 1'b0;
                  end
               end
               `SPX_WORK_X_OFS:    x_r    <= pwdata_i[7:0];
               `SPX_WORK_Y_OFS:    y_r    <= pwdata_i[7:0];
               `SPX_WORK_Z_OFS:    z_r    <= pwdata_i[7:0];
               `SPX_PROG_PTR_OFS:  wptr_r <= pwdata_i[AW-1:0];
               `SPX_PROG_DATA_OFS: wptr_r <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
               `SPX_TCMP_OFS:      tcmp_r <= pwdata_i[TW-1:0];
               default:            wptr_r <= wptr_r;
            endcase
         end
      end
   end

endmodule // spx_exec_core

// file: verification/spx_exec_core_assertions.sv
// Purpose: Port checker for the strobe processor execution core
// Assumes: APB slave answers one cycle after the access edge
// Notes:   Bound to the core from the tb file
`timescale 1ns/1ps
module spx_exec_chk (
   // Clock and reset
   input wire        sys_clk_i,
   input wire        arst_n_i,
   // APB
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   // Flags
   input wire        program_interrupt_flag_o,
   input wire        wait_done_flag_o,
   input wire        running_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Access edge still waiting for its answer, and a status write commit
   wire acc = psel_i && penable_i && !pready_o;
   wire st_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h04;
   a_ready_follows: assert property (acc |=> pready_o) else $error("ready late");
   a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
   a_ready_cause: assert property (!acc |=> !pready_o) else $error("ready unasked");
   a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error without ready");
   a_bad_addr: assert property (acc && paddr_i[1:0] != 2'b00 |=> pslverr_o)
      else $error("odd address accepted");
   a_good_addr: assert property (acc && paddr_i <= 8'h1c && paddr_i[1:0] == 2'b00 |=> !pslverr_o)
      else $error("mapped address refused");
   a_int_sticky: assert property (
      program_interrupt_flag_o && !(st_wr && pwdata_i[1]) |=> program_interrupt_flag_o)
      else $error("interrupt flag lost");
   a_int_cause: assert property ($rose(program_interrupt_flag_o) |-> $past(running_o))
      else $error("interrupt flag while idle");
   a_wait_sticky: assert property (
      wait_done_flag_o && !(st_wr && pwdata_i[2]) |=> wait_done_flag_o)
      else $error("wait flag lost");
   a_wait_cause: assert property ($rose(wait_done_flag_o) |-> $past(running_o))
      else $error("wait flag while idle");
   // Main scenarios
   c_refused: cover property (acc ##1 pslverr_o);
   c_wait_done: cover property ($rose(wait_done_flag_o));
   c_prog_end: cover property ($fell(running_o));
endmodule // spx_exec_chk

// file: verification/spx_mac_model.sv
// Purpose: MAC timer and random source beside the core
// Assumes: Free running timer, overflow pulse every OVF_PER cycles
// Notes:   Random value held constant so loads are predictable
`timescale 1ns/1ps
module spx_mac_model #(
   parameter       OVF_PER = 32,
   parameter [7:0] RNG_VAL = 8'ha7
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   output reg         ovf_o,
   output reg  [15:0] timer_o,
   output wire [7:0]  rng_o
);
   assign rng_o = RNG_VAL;
   // Timer count and one-cycle overflow pulse
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_o <= 16'h0;
         ovf_o   <= 1'b0;
      end else begin
         timer_o <= timer_o + 16'h1;
         ovf_o   <= (timer_o % OVF_PER) == OVF_PER - 1;
      end
   end
endmodule // spx_mac_model

// file: verification/tb.sv
// Purpose: Self-checking bench for the strobe processor execution core
// Assumes: APB master tasks, programs of ten bytes padded with no-ops
// Notes:   Timer and random data come from spx_mac_model
`timescale 1ns/1ps
module tb;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err;
   logic [7:0]  paddr = 0, cond = 0;
   logic [15:0] t0;
   logic [31:0] pwdata = 0, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, ovf, intf, wtf, running;
   wire  [15:0] tmr;
   wire  [7:0]  rng;
   int          num_errors = 0, n_tests = 0;
   initial forever #25 clk = ~clk;
   spx_exec_core spx_exec_core_i (.sys_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .mac_ovf_i(ovf), .mac_timer_i(tmr),
      .random_generator_output_i(rng), .cond_status_i(cond),
      .program_interrupt_flag_o(intf), .wait_done_flag_o(wtf), .running_o(running));
   spx_mac_model spx_mac_model_i (.clk_i(clk), .rst_n_i(rst_n), .ovf_o(ovf), .timer_o(tmr),
      .rng_o(rng));
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 0; pen <= 0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd & m, e);
   endtask
   // Load a program at address zero, pad with no-ops, and start it
   task automatic load(input logic [7:0] p[10]);
      apb(1, 8'h14, 0);
      for (int i = 0; i < 32; i++) apb(1, 8'h18, {24'h0, i < 10 ? p[i] : 8'hc0});
      apb(1, 8'h00, 1);
      @(posedge clk);
   endtask
   // Bounded wait for the program to run off the end of memory
   task automatic finish;
      int i;
      i = 0;
      while (running !== 1'b0 && i < 4000) begin @(posedge clk); i++; end
      if (i == 4000) num_errors++;
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #600000;
      num_errors++;
      give_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      // Arithmetic wrap, interrupt, full-width random load
      apb(1, 8'h08, 5); apb(1, 8'h0c, 8'hff); apb(1, 8'h10, 0);
      load('{8'hbd, 8'hbe, 8'hbe, 8'hb9, 8'hbc, 8'hbc, 8'hbf, 8'hc0, 8'hc0, 8'hc0});
      finish;
      rchk(8'h10, 32'hffffffff, 32'hff);
      rchk(8'h0c, 32'hffffffff, 32'hfe);
      rchk(8'h08, 32'hffffffff, 32'ha7);
      rchk(8'h04, 32'h7, 32'h2);
      chk({31'h0, intf}, 32'h1);
      apb(1, 8'h04, 6);
      rchk(8'h04, 32'h7, 32'h0);
      $display("test arithmetic done");
      // Waits, repeat without label, skip, saturating increment, narrow random load
      apb(1, 8'h08, 3); apb(1, 8'h0c, 8'hff); apb(1, 8'h10, 8'h10); apb(1, 8'h1c, 32'h400);
      cond <= 8'h02;
      load('{8'hbb, 8'h82, 8'hb8, 8'haf, 8'h21, 8'hbf, 8'hbf, 8'hbf, 8'hb5, 8'hbc});
      // Parked on the event wait: X counted down, wait flag up, pc at two
      repeat (250) @(posedge clk);
      rchk(8'h08, 32'hffffffff, 32'h00);
      rchk(8'h04, 32'h3f07, 32'h0205);
      finish;
      chk({31'h0, tmr >= 16'h0400}, 32'h1);
      rchk(8'h10, 32'hffffffff, 32'h0f);
      rchk(8'h0c, 32'hffffffff, 32'h05);
      rchk(8'h08, 32'hffffffff, 32'h07);
      rchk(8'h04, 32'h7, 32'h4);
      chk({31'h0, wtf}, 32'h1);
      $display("test waits done");
      // Skip of zero holds until its condition comes true
      apb(1, 8'h10, 8'h10);
      cond <= 8'h00;
      load('{8'h01, 8'hbf, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc0});
      repeat (100) @(posedge clk);
      rchk(8'h10, 32'hffffffff, 32'h10);
      cond <= 8'h02;
      finish;
      rchk(8'h10, 32'hffffffff, 32'h0f);
      $display("test skip hold done");
      // Empty wait, replaced label, repeat loop, then thirty-two overflows
      apb(1, 8'h04, 6);
      apb(1, 8'h08, 0);
      apb(1, 8'h0c, 0);
      cond <= 8'h00;
      load('{8'hbb, 8'hba, 8'hba, 8'hbd, 8'ha9, 8'h80, 8'hc0, 8'hc0, 8'hc0, 8'hc0});
      repeat (200) @(posedge clk);
      cond <= 8'h02;
      t0 = tmr;
      finish;
      chk({31'h0, (tmr - t0 >= 16'h03e0) && (tmr - t0 < 16'h0500)}, 32'h1);
      rchk(8'h08, 32'hffffffff, 32'h00);
      apb(0, 8'h0c, 0);
      chk({31'h0, rd[7:0] > 8'h04}, 32'h1);
      rchk(8'h04, 32'h7, 32'h4);
      $display("test loop done");
      // Refused and write-only places
      apb(1, 8'h22, 1);
      chk({31'h0, err}, 32'h1);
      rchk(8'h00, 32'hffffffff, 32'h0);
      $display("test access done");
      give_verdict;
   end
endmodule // tb
bind spx_exec_core spx_exec_chk spx_exec_chk_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .program_interrupt_flag_o(program_interrupt_flag_o), .wait_done_flag_o(wait_done_flag_o),
   .running_o(running_o));
